// >>> core/rtic_pkg.sv
/*
  Package for the real-time interval counters: widths, tick divider,
  reset values and the carrier structs shared by the counter files.
  Assumes a single 20 MHz core clock; nothing else.
*/
package rtic_pkg;

  // Clock and tick timing
  localparam int unsigned CORE_CLK_HZ   = 20_000_000;
  localparam int unsigned TICK_HZ       = 1_000_000;
  localparam int unsigned TICK_DIV      = CORE_CLK_HZ / TICK_HZ;

  // Field widths and positions
  localparam int unsigned RTC_CNT_W     = 47;
  localparam int unsigned RTC_OUT_W     = 48;
  localparam int unsigned IVL_W         = 24;
  localparam int unsigned JOB_FLAG_BIT  = 36;
  localparam int unsigned MON_IRQ_CHAN  = 15;

  // Reset values
  localparam logic [RTC_CNT_W-1:0] RTC_RESET = 47'h0000_0000_0000;
  localparam logic [IVL_W-1:0]     IVL_RESET = 24'h00_0000;

  // Interval timer state
  typedef enum logic [1:0] {
    RTIC_IDLE = 2'b01,
    RTIC_RUN  = 2'b10
  } rtic_tmr_state_type;

  // Load request carried from the instruction unit
  typedef struct packed {
    logic             load;
    logic [IVL_W-1:0] value;
  } rtic_load_type;

  // Interval timer state record
  typedef struct packed {
    rtic_tmr_state_type state;
    logic [IVL_W-1:0]   count;
    logic               expire;
  } rtic_tmr_type;

endpackage

// >>> core/rtic_interval_timer.sv
/*
  One 24-bit interval down-counter with activity state and an expiry
  pulse. Assumes load and tick come from logic on the same clock.
*/
`timescale 1ns/10ps
module rtic_interval_timer #(
  parameter int unsigned WIDTH = rtic_pkg::IVL_W
) (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // Control
  input  wire logic                 i_tick,
  input  wire logic                 i_run_ok,
  input  wire rtic_pkg::rtic_load_type i_load,
  // State out
  output      rtic_pkg::rtic_tmr_type  o_tmr
);

  // Counts are package-typed, so only the package width can be served
  if (WIDTH != rtic_pkg::IVL_W) $error("rtic_interval_timer: WIDTH must match IVL_W");

  rtic_pkg::rtic_tmr_type tmr_q;
  rtic_pkg::rtic_tmr_type tmr_d;

  // Load wins over a tick in the same cycle; a zero load goes idle quietly
  always_comb begin
    tmr_d        = tmr_q;
    tmr_d.expire = 1'b0;
    if (i_load.load) begin
      tmr_d.count = i_load.value;
      tmr_d.state = (i_load.value != rtic_pkg::IVL_RESET) ? rtic_pkg::RTIC_RUN
                                                          : rtic_pkg::RTIC_IDLE;
    end else if (i_tick && i_run_ok && tmr_q.state == rtic_pkg::RTIC_RUN) begin
      tmr_d.count = tmr_q.count - 24'h00_0001;
      if (tmr_q.count == 24'h00_0001) begin
        tmr_d.state  = rtic_pkg::RTIC_IDLE;
        tmr_d.expire = 1'b1;
      end
    end
  end

  // Registered state; master clear leaves the timer idle at zero. A low enable
  // holds the expiry pulse too, so the frozen upper level still sees it later
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tmr_q <= '{state: rtic_pkg::RTIC_IDLE, count: rtic_pkg::IVL_RESET, expire: 1'b0};
    end else if (i_ce) begin
      tmr_q <= tmr_d;
    end
  end

  assign o_tmr = tmr_q;

endmodule

// >>> core/rtic_counters.sv
/*
  Real-time counters of the scalar processor: free-running microsecond
  clock, monitor interval timer and job interval timer. Assumes the
  instruction unit and exchange sequencer run on i_core_clk and present
  one-cycle request strobes; mode flags are levels from the same logic.
*/
`timescale 1ns/10ps
// Summary of operation
// - 47-bit free-running count advances per 1 MHz tick; read as 48 bits, sign zero.
// - Clock never cleared; copied to destination on transmit-clock instruction.
// - 24-bit monitor timer decrements at 1 MHz; loadable only in monitor mode.
// - Nonzero load activates monitor timer; decrements each tick until zero.
// - Monitor timer reaching zero raises external interrupt channel 15, then idles.
// - Monitor timer deactivated by master clear, zero load, or reaching zero.
// - 24-bit job timer decrements at 1 MHz; loadable only in job mode.
// - Exchange to monitor stops job timer, saves count; resume reloads and continues.
// - Job timer reaching zero sets data flag branch register bit 36.
// - Zero load deactivates job timer without flag; master clear deactivates it.
module rtic_counters #(
  parameter int unsigned TICK_DIV = rtic_pkg::TICK_DIV
) (
  // Clock, reset, enable
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_ce,
  // Mode and instruction strobes
  input  wire logic                          i_monitor_mode,
  input  wire logic                          i_rtc_read,
  input  wire logic                          i_mon_load,
  input  wire logic                          i_job_load,
  input  wire logic [rtic_pkg::IVL_W-1:0]    i_load_value,
  // Exchange sequencer
  input  wire logic                          i_xchg_save,
  input  wire logic                          i_xchg_restore,
  input  wire logic [rtic_pkg::IVL_W-1:0]    i_restore_value,
  // Results
  output logic [rtic_pkg::RTC_OUT_W-1:0]     o_rtc_value,
  output logic                               o_rtc_valid,
  output logic [rtic_pkg::IVL_W-1:0]         o_save_value,
  output logic                               o_save_valid,
  output logic                               o_mon_irq,
  output logic                               o_job_flag_set,
  output logic [rtic_pkg::IVL_W-1:0]         o_mon_count,
  output logic [rtic_pkg::IVL_W-1:0]         o_job_count,
  output logic                               o_mon_active,
  output logic                               o_job_active,
  output logic                               o_tick
);

  // The divider counter is eight bits wide and the tick must be one cycle
  if (TICK_DIV < 2 || TICK_DIV > 255) $error("rtic_counters: TICK_DIV out of range");

  // Whole state of this level in one record
  typedef struct packed {
    logic [7:0]                       div;
    logic                             tick;
    logic [rtic_pkg::RTC_CNT_W-1:0]   rtc;
    logic [rtic_pkg::RTC_OUT_W-1:0]   rtc_out;
    logic                             rtc_valid;
    logic [rtic_pkg::IVL_W-1:0]       save_val;
    logic                             save_valid;
    logic                             job_held;
    logic                             mon_irq;
    logic                             job_flag;
  } rtic_top_type;

  // Power-up value of the clock is a defined zero; master clear never touches it
  rtic_top_type st_q = '{rtc: rtic_pkg::RTC_RESET, default: '0};
  rtic_top_type st_d;

  rtic_pkg::rtic_load_type mon_ld;
  rtic_pkg::rtic_load_type job_ld;
  rtic_pkg::rtic_tmr_type  mon_tmr;
  rtic_pkg::rtic_tmr_type  job_tmr;

  // Load gating by mode; a restore reuses the job load path so the count
  // resumes exactly where it stopped
  always_comb begin
    mon_ld.load  = i_mon_load && i_monitor_mode;
    mon_ld.value = i_load_value;
    job_ld.load  = (i_job_load && !i_monitor_mode) || i_xchg_restore;
    job_ld.value = i_xchg_restore ? i_restore_value : i_load_value;
  end

  rtic_interval_timer #(.WIDTH(rtic_pkg::IVL_W)) u_mon (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_tick     (st_q.tick),
    .i_run_ok   (1'b1),
    .i_load     (mon_ld),
    .o_tmr      (mon_tmr)
  );

  // Job timer is frozen while its job is swapped out
  rtic_interval_timer #(.WIDTH(rtic_pkg::IVL_W)) u_job (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_tick     (st_q.tick),
    .i_run_ok   (!st_q.job_held && !i_xchg_save),
    .i_load     (job_ld),
    .o_tmr      (job_tmr)
  );

  // Tick divider, clock, capture and event pulses
  always_comb begin
    st_d            = st_q;
    st_d.rtc_valid  = 1'b0;
    st_d.save_valid = 1'b0;
    st_d.tick       = 1'b0;
    if (st_q.div == 8'(TICK_DIV - 1)) begin
      st_d.div  = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 8'h01;
    end
    if (st_q.tick) begin
      st_d.rtc = st_q.rtc + 47'h0000_0000_0001;
    end
    if (i_rtc_read) begin
      st_d.rtc_out   = {1'b0, st_q.rtc};
      st_d.rtc_valid = 1'b1;
    end
    if (i_xchg_save) begin
      st_d.save_val   = job_tmr.count;
      st_d.save_valid = 1'b1;
      st_d.job_held   = 1'b1;
    end else if (i_xchg_restore) begin
      st_d.job_held = 1'b0;
    end
    st_d.mon_irq  = mon_tmr.expire;
    st_d.job_flag = job_tmr.expire;
  end

  // Master clear never touches the free-running clock
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q.div        <= 8'h00;
      st_q.tick       <= 1'b0;
      st_q.rtc_out    <= 48'h0000_0000_0000;
      st_q.rtc_valid  <= 1'b0;
      st_q.save_val   <= rtic_pkg::IVL_RESET;
      st_q.save_valid <= 1'b0;
      st_q.job_held   <= 1'b0;
      st_q.mon_irq    <= 1'b0;
      st_q.job_flag   <= 1'b0;
      st_q.rtc        <= st_d.rtc;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops, except the active flags decoded from timer state
  always_comb begin
    o_rtc_value    = st_q.rtc_out;
    o_rtc_valid    = st_q.rtc_valid;
    o_save_value   = st_q.save_val;
    o_save_valid   = st_q.save_valid;
    o_mon_irq      = st_q.mon_irq;
    o_job_flag_set = st_q.job_flag;
    o_mon_count    = mon_tmr.count;
    o_job_count    = job_tmr.count;
    o_mon_active   = (mon_tmr.state == rtic_pkg::RTIC_RUN);
    o_job_active   = (job_tmr.state == rtic_pkg::RTIC_RUN);
    o_tick         = st_q.tick;
  end

  // Checks
  a_rtc_sign_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_rtc_valid |-> !o_rtc_value[rtic_pkg::RTC_OUT_W-1])
    else $error("clock sign bit set");
  a_rtc_advances: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q.tick && i_ce) |=> st_q.rtc == $past(st_q.rtc) + 47'h0000_0000_0001)
    else $error("clock did not advance on tick");
  a_tick_single: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q.tick && i_ce) |=> !st_q.tick)
    else $error("tick longer than one cycle");
  a_mon_load_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_mon_load && !i_monitor_mode && mon_tmr.state == rtic_pkg::RTIC_IDLE)
      |=> mon_tmr.state == rtic_pkg::RTIC_IDLE)
    else $error("monitor timer loaded outside monitor mode");
  a_mon_activate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && mon_ld.load && mon_ld.value != 24'h00_0000) |=> o_mon_active)
    else $error("nonzero load did not activate");
  a_mon_irq_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    mon_tmr.expire |-> (mon_tmr.count == 24'h00_0000 && !o_mon_active))
    else $error("interrupt without zero count");
  a_mon_zero_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && mon_ld.load && mon_ld.value == 24'h00_0000) |=> !o_mon_active)
    else $error("zero load left timer active");
  a_job_load_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_job_load && i_monitor_mode && !i_xchg_restore
      && job_tmr.state == rtic_pkg::RTIC_IDLE) |=> !o_job_active)
    else $error("job timer loaded in monitor mode");
  a_job_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (st_q.job_held && !job_ld.load) |=> $stable(job_tmr.count))
    else $error("held job timer moved");
  a_job_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && job_tmr.expire) |=> o_job_flag_set)
    else $error("job expiry did not set flag");
  a_job_zero_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && job_ld.load && job_ld.value == 24'h00_0000) |=> !job_tmr.expire)
    else $error("zero load raised job flag");

  // Capture, pulse and master clear checks
  a_rtc_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_rtc_read) |=> (o_rtc_valid && o_rtc_value == {1'b0, $past(st_q.rtc)}))
    else $error("clock capture mismatch");
  a_rtc_kept: assert property (@(posedge i_core_clk)
    i_rst |=> (st_q.rtc == $past(st_q.rtc)
      || st_q.rtc == $past(st_q.rtc) + 47'h0000_0000_0001))
    else $error("master clear changed the clock");
  a_save_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_xchg_save) |=> (o_save_valid && o_save_value == $past(job_tmr.count)))
    else $error("saved job count mismatch");
  a_save_freeze: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && i_xchg_save && !job_ld.load) |=> job_tmr.count == $past(job_tmr.count))
    else $error("job timer moved on exchange out");
  a_mon_irq_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && mon_tmr.expire) |=> o_mon_irq)
    else $error("monitor expiry raised no interrupt");
  a_job_flag_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && o_job_flag_set) |=> !o_job_flag_set)
    else $error("job flag pulse longer than one cycle");
  a_job_zero_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && job_ld.load && job_ld.value == 24'h00_0000) |=> !o_job_active)
    else $error("zero load left job timer active");

endmodule

// >>> verification/rtic_xchg_model.sv
/*
  Exchange sequencer stand-in: holds the job timer count in the saved
  state package between an exchange out and the resume.
  Assumes the counters' save pulse and the bench clock.
*/
`timescale 1ns/10ps
module rtic_xchg_model (
  // Clock and save side
  input  wire logic                       i_core_clk,
  input  wire logic                       i_save_valid,
  input  wire logic [rtic_pkg::IVL_W-1:0] i_save_value,
  // Restore side
  output logic [rtic_pkg::IVL_W-1:0]      o_restore_value
);
  // Package slot starts with a pattern, so a resume before any save is visible
  initial o_restore_value = 24'h5a_a5a5;
  always @(posedge i_core_clk) begin
    if (i_save_valid === 1'b1) begin
      o_restore_value <= i_save_value;
    end
  end
endmodule

// >>> verification/realtime_interval_counters_tb.sv
/*
  Self-checking bench for the real-time interval counters.
  Assumes a shortened tick divider; the exchange model keeps saved counts.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module realtime_interval_counters_tb;
  localparam int unsigned TDIV = 4;
  logic        clk = 0, rst = 1, ce = 1, mon = 1, rd = 0, mld = 0, jld = 0, sv = 0, rs = 0;
  logic [23:0] ld_val = 24'h00_0000;
  int          n_checks = 0, n_mismatch = 0, cyc = 0;
  wire  [47:0] o_rtc;
  wire  [23:0] o_sv, o_mc, o_jc, rsv;
  wire         o_rv, o_svv, o_irq, o_flag, o_ma, o_ja, o_tick;

  rtic_counters #(.TICK_DIV(TDIV)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_monitor_mode(mon), .i_rtc_read(rd),
    .i_mon_load(mld), .i_job_load(jld), .i_load_value(ld_val), .i_xchg_save(sv),
    .i_xchg_restore(rs), .i_restore_value(rsv), .o_rtc_value(o_rtc), .o_rtc_valid(o_rv),
    .o_save_value(o_sv), .o_save_valid(o_svv), .o_mon_irq(o_irq), .o_job_flag_set(o_flag),
    .o_mon_count(o_mc), .o_job_count(o_jc), .o_mon_active(o_ma), .o_job_active(o_ja),
    .o_tick(o_tick));
  rtic_xchg_model xm (.i_core_clk(clk), .i_save_valid(o_svv), .i_save_value(o_sv),
    .o_restore_value(rsv));

  // Free clock; the cycle ceiling cuts a hang short
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // One strobe for one edge (0 mon load, 1 job load, 2 restore, 3 save, 4 rtc read)
  task automatic strobe(input int k, input logic [23:0] v, output int t);
    @(negedge clk);
    ld_val = v;
    case (k) 0: mld = 1; 1: jld = 1; 2: rs = 1; 3: sv = 1; default: rd = 1; endcase
    @(posedge clk);
    #1 t = int'(o_tick === 1'b1);
    @(negedge clk);
    {mld, jld, rs, sv, rd} = '0;
  endtask

  // Count ticks over n cycles; optionally stop at the first expiry event
  task automatic run(input int n, input bit stop, output int t, output bit ev);
    t = 0;
    ev = 0;
    repeat (n) begin
      @(posedge clk);
      #1 ev = ev | (o_irq === 1'b1) | (o_flag === 1'b1);
      if (ev && stop) break;
      if (o_tick === 1'b1) t++;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    int t, t2, x;
    bit ev;
    logic [47:0] ra, rb;
    logic [23:0] v, s;
    void'($urandom(32'h38d5_1c19));
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 0;
    // Tick spacing and the free-running clock
    run(TDIV * 10, 0, t, ev);
    `CHK(t, 10)
    strobe(4, 0, x);
    ra = o_rtc;
    run(TDIV * 25, 0, t, ev);
    strobe(4, 0, x);
    rb = o_rtc;
    `CHK(o_rv, 1'b1)
    `CHK(rb[47], 1'b0)
    `CHK((rb - ra >= t) && (rb - ra <= t + 2), 1'b1)
    // Master clear mid-run idles both timers but never clears the clock
    strobe(0, 24'h00_ffff, x);
    mon = 0;
    strobe(1, 24'h00_ffff, x);
    @(negedge clk) rst = 1;
    @(negedge clk) rst = 0;
    `CHK({o_ma, o_ja}, 2'b00)
    strobe(4, 0, x);
    `CHK(o_rtc >= rb, 1'b1)
    $display("test clock done");
    // Monitor timer: corner count 1, then random counts
    mon = 1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 24'h00_0001 : 24'(1 + $urandom % 8);
      strobe(0, v, t);
      `CHK({o_ma, o_mc}, {1'b1, v})
      run(10 * TDIV + 8, 1, t2, ev);
      `CHK(ev, 1'b1)
      `CHK(t + t2, int'(v))
      `CHK(o_ma, 1'b0)
    end
    // Clock enable low freezes a running count and its pending interrupt
    strobe(0, 24'h00_0003, t);
    @(negedge clk) ce = 0;
    run(TDIV * 8, 1, t2, ev);
    `CHK({ev, o_ma, o_mc}, {1'b0, 1'b1, 24'(3 - t)})
    @(negedge clk) ce = 1;
    run(TDIV * 8, 1, t2, ev);
    `CHK({ev, o_ma}, 2'b10)
    strobe(0, 24'h00_0030, x);
    strobe(0, 24'h00_0000, x);
    run(TDIV * 20, 0, t, ev);
    `CHK({ev, o_ma}, 2'b00)
    strobe(1, 24'h00_0005, x);
    `CHK(o_ja, 1'b0)
    mon = 0;
    strobe(0, 24'h00_0005, x);
    `CHK(o_ma, 1'b0)
    $display("test monitor done");
    // Job timer: random counts, then a zero load
    for (int i = 0; i < 3; i++) begin
      v = 24'(1 + $urandom % 8);
      strobe(1, v, t);
      run(10 * TDIV + 8, 1, t2, ev);
      `CHK(ev, 1'b1)
      `CHK(t + t2, int'(v))
      `CHK(o_ja, 1'b0)
    end
    strobe(1, 24'h00_0040, x);
    strobe(1, 24'h00_0000, x);
    run(TDIV * 20, 0, t, ev);
    `CHK({ev, o_ja}, 2'b00)
    // Exchange out mid-count, stay frozen, resume from the saved package
    strobe(1, 24'h00_0010, t);
    run(TDIV * 3, 0, t2, ev);
    @(negedge clk) mon = 1;
    strobe(3, 0, x);
    `CHK(o_svv, 1'b1)
    s = o_sv;
    `CHK(s, 24'(16 - t - t2))
    run(TDIV * 6, 0, t, ev);
    `CHK({ev, o_jc}, {1'b0, s})
    @(negedge clk) mon = 0;
    strobe(2, 0, t);
    run(TDIV * 20, 1, t2, ev);
    `CHK(ev, 1'b1)
    `CHK(t + t2, int'(s))
    $display("test job done");
    wrap_up();
  end
endmodule
